//--- include/tds_defines.vh
`ifndef TDS_DEFINES_VH
`define TDS_DEFINES_VH

// Register byte addresses on the plain register port.
`define TDS_A_CLK_GATE 8'h00
`define TDS_A_PRESCALE 8'h04
`define TDS_A_CH_STOP 8'h08
`define TDS_A_CH_START 8'h0C
`define TDS_A_RELOAD 8'h10
`define TDS_A_TMR_COUNT 8'h14
`define TDS_A_CONV_CTRL 8'h18
`define TDS_A_CONV_VALUE 8'h1C
`define TDS_A_XFER_SRC 8'h20
`define TDS_A_XFER_DST 8'h24
`define TDS_A_XFER_COUNT 8'h28
`define TDS_A_XFER_BASE 8'h2C
`define TDS_A_XFER_CTRL 8'h30
`define TDS_A_TABLE_INDEX 8'h34
`define TDS_A_TABLE_DATA 8'h38
`define TDS_A_STATUS 8'h3C

// Field positions.
`define TDS_B_GATE 0
`define TDS_B_STOP 0
`define TDS_B_START 0
`define TDS_B_CONV_EN 0
`define TDS_B_CONV_RT 1
`define TDS_B_LINK_EN 2
`define TDS_B_XFER_EN 0
`define TDS_PS_MSB 3
`define TDS_PS_LSB 0

// Reset and fixed values.
`define TDS_RELOAD_RST 16'h18FF
`define TDS_PRESCALE_RST 16'h0000
`define TDS_SRC_RST 20'hF_E000
`define TDS_DST_FIXED 20'hF_FF34
`define TDS_BASE_RST 8'hFD
`define TDS_CTRL_AREA_LOW 8'h00
`define TDS_CTRL_AREA_TOP 4'hF
`define TDS_COUNT_RST 8'h63
`define TDS_CONV_RST 8'h00
`define TDS_TABLE_LEN 7'h64
`define TDS_BLOCK_ITEMS 8'h01

`endif

//--- design/tds_prescaler.v
`timescale 1ns/10ps
`default_nettype none

// Free-running divider that yields a one-cycle enable at clock / 2**sel.
module tds_prescaler
(
  input wire i_clk,
  input wire i_rstn,
  input wire i_clear,
  input wire [3:0] i_sel,
  output reg o_tick
);

  reg [14:0] div;
  wire [14:0] mask;

  // Low bits all ones mark the last cycle of each divided period.
  assign mask = ~(15'h7FFF << i_sel);

  // Divider and tick; the selected zero value gives a tick every cycle.
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      div <= 15'h0000;
      o_tick <= 1'b0;
    end
    else if (i_clear)
    begin
      div <= 15'h0000;
      o_tick <= 1'b0;
    end
    else
    begin
      div <= div + 15'h0001;
      o_tick <= ((div & mask) == mask);
    end
  end

endmodule // tds_prescaler

`default_nettype wire

//--- design/tds_top.v
// Functional notes
// - Channel zero interval timer raises a count-end event every period while counting.
// - Channel count source is operation clock zero, the system clock divided by 2**sel from the prescale register.
// - Event link forwards each count-end to the converter as conversion start.
// - Each forwarded event converts the held value onto the analog output.
// - Same event starts a transfer: table byte at pointer into converter value.
// - Each transfer ends by advancing the source pointer, except the last of the count, which reloads the start.
// - Source starts at FE000, increments after each transfer and returns to the start when the count runs out.
// - Destination is fixed at the converter value register FFF34.
// - Each transfer is normal mode, one block of one 8-bit item.
// - Count programmed 63H gives one hundred transfers.
// - Control base FDH places the control area at FFD00.
// - One entry per event gives one sine cycle per hundred entries.
// - Output is zero right after conversion enable; value register starts at zero.
// - Clock gate bit 0 off rejects timer writes and holds timer in reset.
// - Writing 1 to stop bit 0 halts channel zero counting.
// - Reload value defaults to 18FFH.
// - Interval mode counts down and raises no event at count start.
// - Output level is reference times the 8-bit code divided by 256.
`include "tds_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module tds_top
(
  input wire I_CLK,
  input wire I_RSTN,
  input wire [7:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [31:0] O_RDATA,
  output reg [7:0] O_ANALOG_CODE,
  output reg O_COUNT_END,
  output reg O_TIMER_RUN
);

  // Timer array state.
  reg clk_gate;
  reg [15:0] prescale;
  reg [15:0] reload;
  reg [15:0] counter;
  reg running;
  wire op_tick;
  wire tmr_rst;

  // Converter state.
  reg conv_en;
  reg conv_rt;
  reg link_en;
  reg [7:0] conv_value;

  // Transfer controller state.
  reg xfer_en;
  reg [19:0] src_start;
  reg [19:0] src_ptr;
  reg [7:0] count_set;
  reg [7:0] remaining;
  reg [7:0] base;
  reg [6:0] tbl_index;
  reg [7:0] table_mem [0:99];
  wire [19:0] src_off;
  wire [7:0] fetch_byte;
  wire timer_wr;
  wire event_fire;
  wire do_xfer;
  wire src_in_table;
  wire stop_req;
  wire start_req;
  integer i;

  // Timer registers follow the gate; while it is off the unit sits in reset.
  assign tmr_rst = ~clk_gate;
  assign timer_wr = I_WR & clk_gate;
  assign event_fire = running & op_tick & (counter == 16'h0000);
  assign do_xfer = O_COUNT_END & xfer_en;

  // Channel trigger writes, decoded once; both are ignored while the gate is off.
  assign stop_req = timer_wr & (I_ADDR == `TDS_A_CH_STOP) & I_WDATA[`TDS_B_STOP];
  assign start_req = timer_wr & (I_ADDR == `TDS_A_CH_START) & I_WDATA[`TDS_B_START];

  // Table offset of the current source pointer.
  assign src_off = src_ptr - `TDS_SRC_RST;
  assign src_in_table = (src_off < {13'h0000, `TDS_TABLE_LEN});

  // A pointer moved past the table by software fetches zero rather than a stale entry.
  assign fetch_byte = src_in_table ? table_mem[src_off[6:0]] : 8'h00;

  // Operation clock zero divider.
  tds_prescaler u_prescaler
  (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_clear(tmr_rst),
    .i_sel(prescale[`TDS_PS_MSB:`TDS_PS_LSB]),
    .o_tick(op_tick)
  );

  // Clock gate register; always writable since it lives outside the timer.
  always @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      clk_gate <= 1'b0;
    else if (I_WR && I_ADDR == `TDS_A_CLK_GATE)
      clk_gate <= I_WDATA[`TDS_B_GATE];
  end

  // Timer configuration registers, held at their reset values while the gate is off.
  always @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      prescale <= `TDS_PRESCALE_RST;
      reload <= `TDS_RELOAD_RST;
    end
    else if (tmr_rst)
    begin
      prescale <= `TDS_PRESCALE_RST;
      reload <= `TDS_RELOAD_RST;
    end
    else if (timer_wr && I_ADDR == `TDS_A_PRESCALE)
      prescale <= I_WDATA[15:0];
    else if (timer_wr && I_ADDR == `TDS_A_RELOAD)
      reload <= I_WDATA[15:0];
  end

  // Channel zero interval counter; a stop write wins over a start in any cycle.
  always @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      running <= 1'b0;
      counter <= 16'h0000;
      O_COUNT_END <= 1'b0;
      O_TIMER_RUN <= 1'b0;
    end
    else if (tmr_rst)
    begin
      running <= 1'b0;
      counter <= 16'h0000;
      O_COUNT_END <= 1'b0;
      O_TIMER_RUN <= 1'b0;
    end
    else
    begin
      O_COUNT_END <= event_fire;
      if (stop_req)
      begin
        running <= 1'b0;
        O_TIMER_RUN <= 1'b0;
      end
      else if (start_req)
      begin
        running <= 1'b1;
        O_TIMER_RUN <= 1'b1;
        counter <= reload;
      end
      else if (running && op_tick)
      begin
        if (counter == 16'h0000)
          counter <= reload;
        else
          counter <= counter - 16'h0001;
      end
    end
  end

  // Converter control register.
  always @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      conv_en <= 1'b0;
      conv_rt <= 1'b0;
      link_en <= 1'b0;
    end
    else if (I_WR && I_ADDR == `TDS_A_CONV_CTRL)
    begin
      conv_en <= I_WDATA[`TDS_B_CONV_EN];
      conv_rt <= I_WDATA[`TDS_B_CONV_RT];
      link_en <= I_WDATA[`TDS_B_LINK_EN];
    end
  end

  // Converter value register; the transfer fills it, software may also write it.
  always @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      conv_value <= `TDS_CONV_RST;
    else if (do_xfer)
      conv_value <= fetch_byte;
    else if (I_WR && I_ADDR == `TDS_A_CONV_VALUE)
      conv_value <= I_WDATA[7:0];
  end

  // Output code; in real-time mode the event latches the value held before the
  // same event's transfer overwrites it, so each entry plays one period later.
  always @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      O_ANALOG_CODE <= 8'h00;
    else if (!conv_en)
      O_ANALOG_CODE <= 8'h00;
    else if (!conv_rt)
      O_ANALOG_CODE <= conv_value;
    else if (O_COUNT_END && link_en)
      O_ANALOG_CODE <= conv_value;
  end

  // Transfer controller registers, pointer and remaining count.
  always @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      xfer_en <= 1'b0;
      src_start <= `TDS_SRC_RST;
      src_ptr <= `TDS_SRC_RST;
      count_set <= `TDS_COUNT_RST;
      remaining <= `TDS_COUNT_RST;
      base <= `TDS_BASE_RST;
    end
    else if (do_xfer)
    begin
      if (remaining == 8'h00)
      begin
        src_ptr <= src_start;
        remaining <= count_set;
      end
      else
      begin
        src_ptr <= src_ptr + 20'h0_0001;
        remaining <= remaining - `TDS_BLOCK_ITEMS;
      end
    end
    else if (I_WR)
    begin
      case (I_ADDR)
        `TDS_A_XFER_CTRL: xfer_en <= I_WDATA[`TDS_B_XFER_EN];
        `TDS_A_XFER_SRC:
        begin
          src_start <= I_WDATA[19:0];
          src_ptr <= I_WDATA[19:0];
        end
        `TDS_A_XFER_COUNT:
        begin
          count_set <= I_WDATA[7:0];
          remaining <= I_WDATA[7:0];
        end
        `TDS_A_XFER_BASE: base <= I_WDATA[7:0];
        default: xfer_en <= xfer_en;
      endcase
    end
  end

  // Sample table; the data port writes one entry and steps the index.
  always @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      tbl_index <= 7'h00;
      for (i = 0; i < 100; i = i + 1)
        table_mem[i] <= 8'h00;
    end
    else if (I_WR && I_ADDR == `TDS_A_TABLE_INDEX)
      tbl_index <= I_WDATA[6:0];
    else if (I_WR && I_ADDR == `TDS_A_TABLE_DATA)
    begin
      if (tbl_index < `TDS_TABLE_LEN)
        table_mem[tbl_index] <= I_WDATA[7:0];
      tbl_index <= tbl_index + 7'h01;
    end
  end

  // Read data one cycle after the read strobe; timer reads show reset values (reload 18FFH) when gated.
  always @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      O_RDATA <= 32'h0000_0000;
    else if (I_RD)
    begin
      case (I_ADDR)
        `TDS_A_CLK_GATE: O_RDATA <= {31'h0000_0000, clk_gate};
        `TDS_A_PRESCALE: O_RDATA <= {16'h0000, prescale};
        `TDS_A_RELOAD: O_RDATA <= {16'h0000, reload};
        `TDS_A_TMR_COUNT: O_RDATA <= {16'h0000, counter};
        `TDS_A_CONV_CTRL: O_RDATA <= {29'h0000_0000, link_en, conv_rt, conv_en};
        `TDS_A_CONV_VALUE: O_RDATA <= {24'h00_0000, conv_value};
        `TDS_A_XFER_SRC: O_RDATA <= {12'h000, src_ptr};
        `TDS_A_XFER_DST: O_RDATA <= {12'h000, `TDS_DST_FIXED};
        `TDS_A_XFER_COUNT: O_RDATA <= {24'h00_0000, remaining};
        `TDS_A_XFER_BASE: O_RDATA <= {12'h000, `TDS_CTRL_AREA_TOP, base, `TDS_CTRL_AREA_LOW};
        `TDS_A_XFER_CTRL: O_RDATA <= {31'h0000_0000, xfer_en};
        `TDS_A_TABLE_INDEX: O_RDATA <= {25'h000_0000, tbl_index};
        `TDS_A_STATUS: O_RDATA <= {16'h0000, O_ANALOG_CODE, 6'h00, O_COUNT_END, running};
        default: O_RDATA <= 32'h0000_0000;
      endcase
    end
    else
      O_RDATA <= 32'h0000_0000;
  end

endmodule // tds_top

`default_nettype wire

//--- tb/tds_load.sv
`timescale 1ns/10ps
`default_nettype none

module tds_load
#(
  parameter int REF_MV = 5000
)
(
  input wire logic [7:0] i_code,
  output logic [15:0] o_level_mv
);
  // The pin settles to the reference times the code over 256, in millivolts.
  always_comb o_level_mv = 16'(REF_MV * i_code / 256);
endmodule // tds_load

`default_nettype wire

//--- tb/tds_checker_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "tds_defines.vh"

module tds_checker
(
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic [7:0] O_ANALOG_CODE,
  input wire logic O_COUNT_END,
  input wire logic O_TIMER_RUN
);
  logic gate;
  wire start_w = I_WR && I_ADDR == `TDS_A_CH_START && I_WDATA[0];
  wire stop_w = I_WR && I_ADDR == `TDS_A_CH_STOP && I_WDATA[0];

  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  // Shadow of the clock gate, since the checker cannot see inside.
  always_ff @(posedge I_CLK or negedge I_RSTN)
    if (!I_RSTN)
      gate <= 1'b0;
    else if (I_WR && I_ADDR == `TDS_A_CLK_GATE)
      gate <= I_WDATA[0];

  // Timer, transfer and converter relations at the ports.
  evt_pulse_a: assert property (O_COUNT_END |=> !O_COUNT_END)
    else $error("count end longer than one cycle");
  evt_run_a: assert property (O_COUNT_END |-> $past(O_TIMER_RUN))
    else $error("count end while idle");
  no_start_evt_a: assert property ($rose(O_TIMER_RUN) |-> !O_COUNT_END ##1 !O_COUNT_END)
    else $error("event at count start");
  stop_halt_a: assert property (stop_w |=> !O_TIMER_RUN)
    else $error("stop did not halt");
  run_hold_a: assert property (O_TIMER_RUN && !I_WR |=> O_TIMER_RUN)
    else $error("timer stopped by itself");
  start_run_a: assert property (gate && start_w && !stop_w |=> O_TIMER_RUN)
    else $error("start ignored with gate on");
  gate_off_a: assert property ((!gate)[*2] |-> !O_TIMER_RUN && !O_COUNT_END)
    else $error("timer active with gate off");
  code_cause_a: assert property (O_ANALOG_CODE != $past(O_ANALOG_CODE) |->
    $past(O_COUNT_END) || $past(O_COUNT_END, 2) || $past(I_WR) || $past(I_WR, 2))
    else $error("code changed without cause");

  // Main scenarios reached.
  cover property (start_w ##[1:20] O_COUNT_END);
  cover property (stop_w);
  cover property (O_COUNT_END ##1 O_ANALOG_CODE != $past(O_ANALOG_CODE));
endmodule // tds_checker

bind tds_top tds_checker chk_i (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_ANALOG_CODE(O_ANALOG_CODE), .O_COUNT_END(O_COUNT_END), .O_TIMER_RUN(O_TIMER_RUN));

`default_nettype wire

//--- tb/tb_timed_table_dac_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "tds_defines.vh"

module tb_timed_table_dac_sequencer;
  logic I_CLK, I_RSTN, I_WR, I_RD;
  logic [7:0] I_ADDR;
  logic [31:0] I_WDATA;
  wire [31:0] O_RDATA;
  wire [7:0] O_ANALOG_CODE;
  wire O_COUNT_END, O_TIMER_RUN;
  wire [15:0] level_mv;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  // Block under test with the analog load on its output.
  tds_top DUT (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_ANALOG_CODE(O_ANALOG_CODE),
    .O_COUNT_END(O_COUNT_END), .O_TIMER_RUN(O_TIMER_RUN));
  tds_load load (.i_code(O_ANALOG_CODE), .o_level_mv(level_mv));

  // Clock of 25 ns.
  initial
  begin
    I_CLK = 1'b0;
    forever #12.5 I_CLK = ~I_CLK;
  end

  // Hang guard.
  always @(posedge I_CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
      $display("BAD %0t got %h expected %h", $time, got, exp);
    if (got !== exp)
      n_mismatch++;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    chk(O_RDATA, exp);
  endtask

  // Counts cycles up to the next count end, giving up at 100.
  task automatic wait_evt(output int n);
    n = 0;
    do
    begin
      @(posedge I_CLK);
      #1;
      n++;
    end
    while (O_COUNT_END !== 1'b1 && n < 100);
  endtask

  // Software's sample for entry k: 127 times sin(phase + 3/4 cycle) + 128, rounded.
  function automatic logic [7:0] sine_code(input int k);
    real ph;
    int v;
    ph = 6.28318530717959 * (k / 100.0 + 0.75);
    v = $rtoi(127.0 * $sin(ph) + 128.5);
    return v[7:0];
  endfunction

  task automatic t_reset();
    rd(`TDS_A_RELOAD, 32'h0000_18FF);
    rd(`TDS_A_XFER_SRC, 32'h000F_E000);
    rd(`TDS_A_XFER_DST, 32'h000F_FF34);
    rd(`TDS_A_XFER_COUNT, 32'h0000_0063);
    rd(`TDS_A_XFER_BASE, 32'h000F_FD00);
    rd(`TDS_A_CONV_VALUE, 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
    $display("test reset values done");
  endtask

  task automatic t_gate();
    wr(`TDS_A_RELOAD, 32'h0000_0009);
    rd(`TDS_A_RELOAD, 32'h0000_18FF);
    wr(`TDS_A_CH_START, 32'h0000_0001);
    cyc(1);
    chk(O_TIMER_RUN, 32'h0000_0000);
    wr(`TDS_A_CLK_GATE, 32'h0000_0001);
    wr(`TDS_A_RELOAD, 32'h0000_0009);
    rd(`TDS_A_RELOAD, 32'h0000_0009);
    $display("test clock gate done");
  endtask

  task automatic t_timer();
    int n;
    wr(`TDS_A_CH_START, 32'h0000_0001);
    wait_evt(n);
    chk(n >= 10 && n <= 11, 32'h0000_0001);
    wait_evt(n);
    chk(n, 32'h0000_000A);
    wr(`TDS_A_PRESCALE, 32'h0000_0001);
    repeat (3) wait_evt(n);
    chk(n, 32'h0000_0014);
    wr(`TDS_A_PRESCALE, 32'h0000_0000);
    $display("test timer period done");
  endtask

  task automatic t_xfer();
    int n;
    wr(`TDS_A_CH_STOP, 32'h0000_0001);
    wr(`TDS_A_TABLE_INDEX, 32'h0000_0000);
    for (int i = 0; i < 100; i++)
      wr(`TDS_A_TABLE_DATA, i * 2 + 1);
    wr(`TDS_A_CONV_CTRL, 32'h0000_0001);
    cyc(2);
    chk(O_ANALOG_CODE, 32'h0000_0000);
    wr(`TDS_A_CONV_CTRL, 32'h0000_0007);
    wr(`TDS_A_XFER_CTRL, 32'h0000_0001);
    wr(`TDS_A_CH_START, 32'h0000_0001);
    repeat (3) wait_evt(n);
    wr(`TDS_A_CH_STOP, 32'h0000_0001);
    #1;
    chk(O_TIMER_RUN, 32'h0000_0000);
    rd(`TDS_A_XFER_SRC, 32'h000F_E003);
    rd(`TDS_A_CONV_VALUE, 32'h0000_0005);
    rd(`TDS_A_XFER_DST, 32'h000F_FF34);
    chk(O_ANALOG_CODE, 32'h0000_0003);
    chk(level_mv, 32'h0000_003A);
    wait_evt(n);
    chk(n, 32'h0000_0064);
    $display("test transfer and stop done");
  endtask

  // Sine table played through one full wrap of the transfer count.
  task automatic t_wave();
    int n;
    wr(`TDS_A_TABLE_INDEX, 32'h0000_0000);
    for (int i = 0; i < 100; i++)
      wr(`TDS_A_TABLE_DATA, {24'h00_0000, sine_code(i)});
    wr(`TDS_A_XFER_SRC, 32'h000F_E000);
    wr(`TDS_A_XFER_COUNT, 32'h0000_0063);
    wr(`TDS_A_CH_START, 32'h0000_0001);
    repeat (100) wait_evt(n);
    rd(`TDS_A_XFER_SRC, 32'h000F_E000);
    rd(`TDS_A_XFER_COUNT, 32'h0000_0063);
    rd(`TDS_A_CONV_VALUE, {24'h00_0000, sine_code(99)});
    chk(O_ANALOG_CODE, {24'h00_0000, sine_code(98)});
    wait_evt(n);
    cyc(1);
    chk(O_ANALOG_CODE, {24'h00_0000, sine_code(99)});
    rd(`TDS_A_CONV_VALUE, {24'h00_0000, sine_code(0)});
    wr(`TDS_A_CH_STOP, 32'h0000_0001);
    $display("test waveform wrap done");
  endtask

  // Reset, then the scenarios in turn.
  initial
  begin
    I_RSTN = 1'b0;
    I_WR = 1'b0;
    I_RD = 1'b0;
    I_ADDR = 8'h00;
    I_WDATA = 32'h0000_0000;
    repeat (5) @(posedge I_CLK);
    I_RSTN <= 1'b1;
    t_reset();
    t_gate();
    t_timer();
    t_xfer();
    t_wave();
    end_sim();
  end
endmodule // tb_timed_table_dac_sequencer

`default_nettype wire
